/* File: hw/sgd_top.sv */
// sgd_top: four scatter-gather channel command engines feeding a legacy
// DMA controller, with register port, completion queues and interrupt.
// assumes the legacy controller pulses I_TC per channel at terminal count
// and the packet memory answers one header read at a time.
// Contract
// - four independent channel command copies, 0..3
// - command bits 7:3 read zero
// - header flag matters only for packet memory
// - ISA target: register address, size minus one
// - packet, no header: size-1, address packet:00
// - header present: count is header size minus nine
// - header size eight: no transfer, queue packet
// - packet write: size-1 count, size+8 at six
// - channel-on bit enables or disables channel
// - disable on packet memory: queue packet, idle
// - disable on ISA memory: abandon, idle
// - paired disable: queue managed packet, no updates
// - pairing only between packet and ISA memory
// - busy reads one while transfer runs
// - ISA-to-packet: advance address, shrink size, min
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "sgd_cfg.svh"

module sgd_top
	import sgd_pkg::*;
(
	// clock and reset
	input  wire logic       I_MCLK,
	input  wire logic       I_RST_N,
	// register port
	input  wire sgd_byte_t  I_ADDR,
	input  wire sgd_byte_t  I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output sgd_byte_t       O_RDATA,
	// legacy controller load and terminal count
	output logic            O_LD_STB,
	output sgd_ch_t         O_LD_CH,
	output sgd_word_t       O_LD_CNT,
	output sgd_word_t       O_LD_ADR,
	output logic            O_LD_M2M,
	output sgd_word_t       O_LD_ADR1,
	input  wire logic [3:0] I_TC,
	// packet header read
	output logic            O_HDR_RD,
	output sgd_byte_t       O_HDR_PKT,
	input  wire logic       I_HDR_VLD,
	input  wire sgd_word_t  I_HDR_SIZE,
	// packet memory size write
	output logic            O_PM_WR,
	output sgd_byte_t       O_PM_PKT,
	output sgd_byte_t       O_PM_OFS,
	output sgd_word_t       O_PM_DATA,
	// interrupt
	output logic            O_IRQ
);

	function automatic sgd_word_t f_dec(input sgd_word_t x);
		f_dec = x - 16'h0001;
	endfunction

	function automatic sgd_word_t f_min(input sgd_word_t a, input sgd_word_t b);
		f_min = (a < b) ? a : b;
	endfunction

	// lowest-numbered requester wins; the others keep requesting until each is granted in turn
	function automatic sgd_ch_t f_first(input logic [3:0] r);
		f_first = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (r[i]) begin
				f_first = 2'(i);
			end
		end
	endfunction

	// register state
	logic [3:0][7:0]  cmd_q, cmd_d, pkt_q, pkt_d;
	logic [3:0][15:0] size_q, size_d, adr_q, adr_d;
	logic [3:0]       start_q, start_d;
	sgd_byte_t        mode_q, mode_d, ists_q, ists_d, imsk_q, imsk_d;
	logic             irq_q, irq_d;
	// channel state
	sgd_state_t [3:0] st_q, st_d;
	logic [3:0][15:0] cnt_q, cnt_d;
	logic             hbusy_q, hbusy_d;
	sgd_ch_t          hch_q, hch_d;
	logic             ld_stb_q, ld_stb_d, ld_m2m_q, ld_m2m_d;
	sgd_ch_t          ld_ch_q, ld_ch_d;
	sgd_word_t        ld_cnt_q, ld_cnt_d, ld_adr_q, ld_adr_d, ld_adr1_q, ld_adr1_d;
	logic             hrd_q, hrd_d, pmwr_q, pmwr_d;
	sgd_byte_t        hpkt_q, hpkt_d, pmpkt_q, pmpkt_d;
	sgd_word_t        pmdat_q, pmdat_d;
	sgd_byte_t        rdata_q, rdata_d;
	// events and decode
	logic [3:0]       push, done_ev, abort_ev, start_clr, pop, q_empty, q_full, busy;
	logic [3:0]       en, pmsel, hdr, pmwrite, ld_req, hdr_req;
	logic [3:0][7:0]  q_data;
	logic             m2m, m2m_tc, win_ch;
	sgd_ch_t          mgd, gnt_ld, gnt_hdr, a_ch;
	logic [2:0]       a_reg;
	sgd_word_t        moved;

	assign m2m    = mode_q[`SGD_MODE_M2M];
	assign mgd    = pmsel[1] ? 2'h1 : 2'h0;
	assign win_ch = (I_ADDR[7:5] == `SGD_WIN_CH);
	assign a_ch   = I_ADDR[4:3];
	assign a_reg  = I_ADDR[2:0];
	assign moved  = cnt_q[0] + 16'h0001;

	always_comb begin
		for (int c = 0; c < 4; c++) begin
			en[c]      = cmd_q[c][`SGD_CMD_EN];
			pmsel[c]   = cmd_q[c][`SGD_CMD_PMSEL];
			hdr[c]     = cmd_q[c][`SGD_CMD_HDR];
			pmwrite[c] = mode_q[`SGD_MODE_WR_LSB + c];
			ld_req[c]  = (st_q[c] == SGD_LOAD);
			hdr_req[c] = (st_q[c] == SGD_HDR);
			// channel 1 is held busy by a paired run on channel 0
			busy[c]    = (st_q[c] != SGD_IDLE) ||
			             (m2m && (c == 1) && (st_q[0] != SGD_IDLE));
			pop[c]     = I_RD && win_ch && (a_ch == 2'(c)) && (a_reg == `SGD_REG_QUEUE);
		end
	end

	assign gnt_ld  = f_first(ld_req);
	assign gnt_hdr = f_first(hdr_req);

	// channel sequencing
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		hbusy_d   = hbusy_q;
		hch_d     = hch_q;
		ld_stb_d  = 1'b0;
		ld_ch_d   = ld_ch_q;
		ld_cnt_d  = ld_cnt_q;
		ld_adr_d  = ld_adr_q;
		ld_adr1_d = ld_adr1_q;
		ld_m2m_d  = ld_m2m_q;
		hrd_d     = 1'b0;
		hpkt_d    = hpkt_q;
		pmwr_d    = 1'b0;
		pmpkt_d   = pmpkt_q;
		pmdat_d   = pmdat_q;
		push      = '0;
		done_ev   = '0;
		abort_ev  = '0;
		start_clr = '0;
		m2m_tc    = 1'b0;
		if (I_HDR_VLD) begin
			hbusy_d = 1'b0;
		end
		for (int c = 0; c < 4; c++) begin
			unique case (st_q[c])
				SGD_IDLE: begin
					if (en[c] && start_q[c] && !(m2m && (c == 1))) begin
						start_clr[c] = 1'b1;
						if (pmsel[c] && hdr[c] && !pmwrite[c] && !(m2m && c == 0)) begin
							st_d[c] = SGD_HDR;
						end else if (m2m && (c == 0)) begin
							cnt_d[c] = f_dec(f_min(size_q[0], size_q[1]));
							st_d[c]  = SGD_LOAD;
						end else begin
							cnt_d[c] = f_dec(size_q[c]);
							st_d[c]  = SGD_LOAD;
						end
					end
				end
				SGD_HDR: begin
					if (!hbusy_q && (gnt_hdr == 2'(c))) begin
						hrd_d   = 1'b1;
						hpkt_d  = pkt_q[c];
						hbusy_d = 1'b1;
						hch_d   = 2'(c);
					end
					if (I_HDR_VLD && hbusy_q && (hch_q == 2'(c))) begin
						if (I_HDR_SIZE == `SGD_HDR_EMPTY) begin
							push[c]    = 1'b1;
							done_ev[c] = 1'b1;
							st_d[c]    = SGD_IDLE;
						end else begin
							cnt_d[c] = I_HDR_SIZE - `SGD_HDR_OVH;
							st_d[c]  = SGD_LOAD;
						end
					end
				end
				SGD_LOAD: begin
					if (gnt_ld == 2'(c)) begin
						ld_stb_d  = 1'b1;
						ld_ch_d   = 2'(c);
						ld_cnt_d  = cnt_q[c];
						ld_adr_d  = pmsel[c] ? {pkt_q[c], `SGD_ADR_LO_PM} : adr_q[c];
						ld_m2m_d  = m2m && (c == 0);
						ld_adr1_d = pmsel[1] ? {pkt_q[1], `SGD_ADR_LO_PM} : adr_q[1];
						if (pmwrite[c] && pmsel[c]) begin
							pmwr_d  = 1'b1;
							pmpkt_d = pkt_q[c];
							pmdat_d = size_q[c] + `SGD_HDR_ADD;
						end
						if (m2m && (c == 0) && pmsel[1] && hdr[1]) begin
							pmwr_d  = 1'b1;
							pmpkt_d = pkt_q[1];
							pmdat_d = cnt_q[0] + 16'h0001 + `SGD_HDR_ADD;
						end
						st_d[c] = SGD_RUN;
					end
				end
				SGD_RUN: begin
					if (I_TC[c]) begin
						st_d[c] = SGD_IDLE;
						if (m2m && (c == 0)) begin
							m2m_tc       = 1'b1;
							push[mgd]    = 1'b1;
							done_ev[mgd] = 1'b1;
						end else if (pmsel[c]) begin
							push[c]    = 1'b1;
							done_ev[c] = 1'b1;
						end
					end
				end
			endcase
			// a disable before terminal count wins over everything above
			if ((st_q[c] != SGD_IDLE) && (!en[c] || (m2m && (c == 0) && !en[1]))) begin
				st_d[c]     = SGD_IDLE;
				abort_ev[c] = 1'b1;
				done_ev[c]  = 1'b0;
				// a load granted in the disabling cycle would start an orphan transfer
				if ((st_q[c] == SGD_LOAD) && (gnt_ld == 2'(c))) begin
					ld_stb_d  = 1'b0;
					ld_ch_d   = ld_ch_q;
					ld_cnt_d  = ld_cnt_q;
					ld_adr_d  = ld_adr_q;
					ld_m2m_d  = ld_m2m_q;
					ld_adr1_d = ld_adr1_q;
					pmwr_d    = 1'b0;
				end
				if ((st_q[c] == SGD_HDR) && !hbusy_q && (gnt_hdr == 2'(c))) begin
					hrd_d   = 1'b0;
					hbusy_d = 1'b0;
				end
				if (m2m && (c == 0)) begin
					m2m_tc       = 1'b0;
					push[1:0]    = 2'b00;
					done_ev[1:0] = 2'b00;
					push[mgd]    = 1'b1;
				end else begin
					push[c] = pmsel[c];
				end
			end
		end
	end

	// register file
	always_comb begin
		cmd_d   = cmd_q;
		size_d  = size_q;
		adr_d   = adr_q;
		pkt_d   = pkt_q;
		start_d = start_q & ~start_clr;
		mode_d  = mode_q;
		imsk_d  = imsk_q;
		ists_d  = ists_q;
		if (I_WR && win_ch) begin
			unique case (a_reg)
				`SGD_REG_CMD:     cmd_d[a_ch] = I_WDATA & `SGD_CMD_MASK;
				`SGD_REG_SIZE_HI: size_d[a_ch][15:8] = I_WDATA;
				`SGD_REG_SIZE_LO: size_d[a_ch][7:0] = I_WDATA;
				`SGD_REG_ADR_HI:  adr_d[a_ch][15:8] = I_WDATA;
				`SGD_REG_ADR_LO:  adr_d[a_ch][7:0] = I_WDATA;
				`SGD_REG_PKT: begin
					pkt_d[a_ch]   = I_WDATA;
					start_d[a_ch] = 1'b1;
				end
				`SGD_REG_STS:     ;
				`SGD_REG_QUEUE:   ;
			endcase
		end
		if (I_WR && (I_ADDR == `SGD_REG_MODE)) begin
			mode_d = I_WDATA;
		end
		if (I_WR && (I_ADDR == `SGD_REG_IRQ_MSK)) begin
			imsk_d = I_WDATA;
		end
		if (I_WR && (I_ADDR == `SGD_REG_IRQ_STS)) begin
			ists_d = ists_q & ~I_WDATA;
		end
		// an event in the clearing cycle still lands
		ists_d = ists_d | {abort_ev, done_ev};
		// paired updates only on a clean terminal count
		if (m2m_tc) begin
			if (!pmsel[0]) begin
				adr_d[0]  = adr_q[0] + moved;
				size_d[0] = size_q[0] - moved;
			end else begin
				adr_d[1] = adr_q[1] + moved;
			end
		end
	end

	assign irq_d = |(ists_d & imsk_d);

	// read port: data stand in the cycle after the strobe only
	always_comb begin
		rdata_d = `SGD_RST_BYTE;
		if (I_RD && win_ch) begin
			unique case (a_reg)
				`SGD_REG_CMD:     rdata_d = cmd_q[a_ch] & `SGD_CMD_MASK;
				`SGD_REG_SIZE_HI: rdata_d = size_q[a_ch][15:8];
				`SGD_REG_SIZE_LO: rdata_d = size_q[a_ch][7:0];
				`SGD_REG_ADR_HI:  rdata_d = adr_q[a_ch][15:8];
				`SGD_REG_ADR_LO:  rdata_d = adr_q[a_ch][7:0];
				`SGD_REG_PKT:     rdata_d = pkt_q[a_ch];
				`SGD_REG_STS: begin
					rdata_d[`SGD_STS_BUSY]   = busy[a_ch];
					rdata_d[`SGD_STS_QFULL]  = q_full[a_ch];
					rdata_d[`SGD_STS_QEMPTY] = q_empty[a_ch];
				end
				`SGD_REG_QUEUE:   rdata_d = q_empty[a_ch] ? `SGD_RST_BYTE : q_data[a_ch];
			endcase
		end else if (I_RD && (I_ADDR == `SGD_REG_MODE)) begin
			rdata_d = mode_q;
		end else if (I_RD && (I_ADDR == `SGD_REG_IRQ_STS)) begin
			rdata_d = ists_q;
		end else if (I_RD && (I_ADDR == `SGD_REG_IRQ_MSK)) begin
			rdata_d = imsk_q;
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_cq
		sgd_cq u_cq (
			.i_clk   (I_MCLK),
			.i_rst_n (I_RST_N),
			.i_push  (push[g]),
			.i_data  (pkt_q[g]),
			.i_pop   (pop[g]),
			.o_data  (q_data[g]),
			.o_empty (q_empty[g]),
			.o_full  (q_full[g])
		);
	end

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int c = 0; c < 4; c++) begin
				cmd_q[c]  <= `SGD_RST_CMD;
				pkt_q[c]  <= `SGD_RST_BYTE;
				size_q[c] <= `SGD_RST_WORD;
				adr_q[c]  <= `SGD_RST_WORD;
				cnt_q[c]  <= `SGD_RST_WORD;
				st_q[c]   <= SGD_IDLE;
			end
			start_q   <= '0;
			mode_q    <= `SGD_RST_BYTE;
			ists_q    <= `SGD_RST_BYTE;
			imsk_q    <= `SGD_RST_BYTE;
			irq_q     <= 1'b0;
			hbusy_q   <= 1'b0;
			hch_q     <= 2'h0;
			ld_stb_q  <= 1'b0;
			ld_ch_q   <= 2'h0;
			ld_cnt_q  <= `SGD_RST_WORD;
			ld_adr_q  <= `SGD_RST_WORD;
			ld_adr1_q <= `SGD_RST_WORD;
			ld_m2m_q  <= 1'b0;
			hrd_q     <= 1'b0;
			hpkt_q    <= `SGD_RST_BYTE;
			pmwr_q    <= 1'b0;
			pmpkt_q   <= `SGD_RST_BYTE;
			pmdat_q   <= `SGD_RST_WORD;
			rdata_q   <= `SGD_RST_BYTE;
		end else begin
			cmd_q     <= cmd_d;
			pkt_q     <= pkt_d;
			size_q    <= size_d;
			adr_q     <= adr_d;
			cnt_q     <= cnt_d;
			st_q      <= st_d;
			start_q   <= start_d;
			mode_q    <= mode_d;
			ists_q    <= ists_d;
			imsk_q    <= imsk_d;
			irq_q     <= irq_d;
			hbusy_q   <= hbusy_d;
			hch_q     <= hch_d;
			ld_stb_q  <= ld_stb_d;
			ld_ch_q   <= ld_ch_d;
			ld_cnt_q  <= ld_cnt_d;
			ld_adr_q  <= ld_adr_d;
			ld_adr1_q <= ld_adr1_d;
			ld_m2m_q  <= ld_m2m_d;
			hrd_q     <= hrd_d;
			hpkt_q    <= hpkt_d;
			pmwr_q    <= pmwr_d;
			pmpkt_q   <= pmpkt_d;
			pmdat_q   <= pmdat_d;
			rdata_q   <= rdata_d;
		end
	end

	assign O_RDATA   = rdata_q;
	assign O_LD_STB  = ld_stb_q;
	assign O_LD_CH   = ld_ch_q;
	assign O_LD_CNT  = ld_cnt_q;
	assign O_LD_ADR  = ld_adr_q;
	assign O_LD_M2M  = ld_m2m_q;
	assign O_LD_ADR1 = ld_adr1_q;
	assign O_HDR_RD  = hrd_q;
	assign O_HDR_PKT = hpkt_q;
	assign O_PM_WR   = pmwr_q;
	assign O_PM_PKT  = pmpkt_q;
	assign O_PM_OFS  = `SGD_SIZE_OFS;
	assign O_PM_DATA = pmdat_q;
	assign O_IRQ     = irq_q;

endmodule // sgd_top

/* File: hw/sgd_cfg.svh */
// sgd_cfg.svh: offsets, field positions, reset values and constants
// of the scatter-gather channel command block; definitions only
`ifndef SGD_CFG_SVH
`define SGD_CFG_SVH

// per-channel window: addr[7:5]=0, addr[4:3]=channel, addr[2:0]=register
`define SGD_REG_CMD     3'h0
`define SGD_REG_SIZE_HI 3'h1
`define SGD_REG_SIZE_LO 3'h2
`define SGD_REG_ADR_HI  3'h3
`define SGD_REG_ADR_LO  3'h4
`define SGD_REG_PKT     3'h5
`define SGD_REG_STS     3'h6
`define SGD_REG_QUEUE   3'h7
`define SGD_WIN_CH      3'h0
// block-wide registers
`define SGD_REG_MODE    8'h20
`define SGD_REG_IRQ_STS 8'h21
`define SGD_REG_IRQ_MSK 8'h22

// channel_command fields
`define SGD_CMD_EN      0
`define SGD_CMD_PMSEL   1
`define SGD_CMD_HDR     2
`define SGD_CMD_MASK    8'h07
`define SGD_RST_CMD     8'h00
// status fields
`define SGD_STS_BUSY    7
`define SGD_STS_QFULL   3
`define SGD_STS_QEMPTY  2
// mode fields: bit 0 pairs channels 0/1, bits 7:4 packet_memory_write per channel
`define SGD_MODE_M2M    0
`define SGD_MODE_WR_LSB 4
`define SGD_RST_BYTE    8'h00
`define SGD_RST_WORD    16'h0000

// header arithmetic
`define SGD_HDR_OVH     16'h0009
`define SGD_HDR_EMPTY   16'h0008
`define SGD_HDR_ADD     16'h0008
`define SGD_SIZE_OFS    8'h06
`define SGD_ADR_LO_PM   8'h00

// completion_queue geometry
`define SGD_CQ_DEPTH    4
`define SGD_CQ_AW       2

`endif

/* File: hw/sgd_pkg.sv */
// sgd_pkg: types shared by the scatter-gather channel command block
// assumes nothing of its surroundings
package sgd_pkg;

	// gray along idle -> header -> load -> run -> idle
	typedef enum logic [1:0] {
		SGD_IDLE = 2'b00,
		SGD_HDR  = 2'b01,
		SGD_LOAD = 2'b11,
		SGD_RUN  = 2'b10
	} sgd_state_t;

	typedef logic [15:0] sgd_word_t;
	typedef logic [7:0]  sgd_byte_t;
	typedef logic [1:0]  sgd_ch_t;

endpackage

/* File: hw/sgd_cq.sv */
// sgd_cq: one completion_queue, a small FIFO of packet numbers
// assumes push and pop are never both asked of an illegal state
`timescale 1ns/100ps
`include "sgd_cfg.svh"

module sgd_cq
	import sgd_pkg::*;
(
	// clock and reset
	input  wire logic      i_clk,
	input  wire logic      i_rst_n,
	// fill side
	input  wire logic      i_push,
	input  wire sgd_byte_t i_data,
	// drain side
	input  wire logic      i_pop,
	output sgd_byte_t      o_data,
	output logic           o_empty,
	output logic           o_full
);

	sgd_byte_t              mem_q [`SGD_CQ_DEPTH];
	sgd_byte_t              mem_d [`SGD_CQ_DEPTH];
	logic [`SGD_CQ_AW-1:0]  wp_q, wp_d, rp_q, rp_d;
	logic [`SGD_CQ_AW:0]    n_q, n_d;
	logic                   do_push, do_pop;

	// a push into a full queue is dropped; firmware sees full in status
	assign do_push = i_push && (n_q != (`SGD_CQ_AW+1)'(`SGD_CQ_DEPTH));
	assign do_pop  = i_pop && (n_q != '0);

	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		n_d   = n_q;
		if (do_push) begin
			mem_d[wp_q] = i_data;
			wp_d        = wp_q + 1'b1;
		end
		if (do_pop) begin
			rp_d = rp_q + 1'b1;
		end
		if (do_push && !do_pop) begin
			n_d = n_q + 1'b1;
		end else if (do_pop && !do_push) begin
			n_d = n_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < `SGD_CQ_DEPTH; i++) begin
				mem_q[i] <= `SGD_RST_BYTE;
			end
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			n_q   <= n_d;
		end
	end

	assign o_data  = mem_q[rp_q];
	assign o_empty = (n_q == '0);
	assign o_full  = (n_q == (`SGD_CQ_AW+1)'(`SGD_CQ_DEPTH));

endmodule // sgd_cq

/* File: tb/sgd_top_checker.sv */
// sgd_top_checker: port-level assertions for sgd_top
// assumes it is bound to sgd_top and sees its ports only
`timescale 1ns/100ps
`include "sgd_cfg.svh"
module sgd_top_checker
	import sgd_pkg::*;
(
	input wire logic      I_MCLK,
	input wire logic      I_RST_N,
	input wire sgd_byte_t I_ADDR,
	input wire sgd_byte_t I_WDATA,
	input wire logic      I_WR,
	input wire logic      I_RD,
	input wire sgd_byte_t O_RDATA,
	input wire logic      O_LD_STB,
	input wire sgd_ch_t   O_LD_CH,
	input wire sgd_word_t O_LD_CNT,
	input wire logic      O_HDR_RD,
	input wire logic      I_HDR_VLD,
	input wire sgd_word_t I_HDR_SIZE,
	input wire logic      O_PM_WR,
	input wire sgd_byte_t O_PM_OFS,
	input wire logic      O_IRQ
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	logic hdr_out_q;
	logic hdr_out_d;
	logic off_wr;
	assign off_wr = I_WR && I_ADDR[7:5] == 3'h0 && I_ADDR[2:0] == `SGD_REG_CMD && !I_WDATA[0];
	always_comb begin
		hdr_out_d = hdr_out_q;
		if (O_HDR_RD)
			hdr_out_d = 1'b1;
		else if (I_HDR_VLD)
			hdr_out_d = 1'b0;
	end
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N)
			hdr_out_q <= 1'b0;
		else
			hdr_out_q <= hdr_out_d;
	end
	property p_rst_quiet;
		$rose(I_RST_N) |-> !O_LD_STB && !O_HDR_RD && !O_PM_WR && !O_IRQ;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
	property p_cmd_rsv;
		I_RD && I_ADDR[7:5] == 3'h0 && I_ADDR[2:0] == `SGD_REG_CMD |=> O_RDATA[7:3] == 5'h00;
	endproperty
	a_cmd_rsv: assert property (p_cmd_rsv) else $error("command upper bits not zero");
	property p_ld_once;
		O_LD_STB |=> !(O_LD_STB && O_LD_CH == $past(O_LD_CH));
	endproperty
	a_ld_once: assert property (p_ld_once) else $error("load strobe repeated");
	property p_hdr_ld;
		I_HDR_VLD && I_HDR_SIZE != `SGD_HDR_EMPTY
			|-> ##2 O_LD_STB && O_LD_CNT == $past(I_HDR_SIZE, 2) - `SGD_HDR_OVH;
	endproperty
	a_hdr_ld: assert property (p_hdr_ld) else $error("header count wrong");
	property p_hdr_empty;
		I_HDR_VLD && I_HDR_SIZE == `SGD_HDR_EMPTY |=> !O_LD_STB [*4];
	endproperty
	a_hdr_empty: assert property (p_hdr_empty) else $error("load for empty packet");
	property p_pm_ofs;
		O_PM_WR |-> O_LD_STB && O_PM_OFS == `SGD_SIZE_OFS;
	endproperty
	a_pm_ofs: assert property (p_pm_ofs) else $error("size written at wrong offset");
	property p_hdr_one;
		O_HDR_RD |-> !hdr_out_q;
	endproperty
	a_hdr_one: assert property (p_hdr_one) else $error("second header read outstanding");
	property p_off_noload;
		off_wr |-> ##3 !O_LD_STB [*4];
	endproperty
	a_off_noload: assert property (p_off_noload) else $error("load after disable");
	property p_irq_mask;
		I_WR && I_ADDR == `SGD_REG_IRQ_MSK && I_WDATA == 8'h00 |=> ##1 !O_IRQ;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
	c_ld: cover property (O_LD_STB);
	c_empty: cover property (I_HDR_VLD && I_HDR_SIZE == `SGD_HDR_EMPTY);
	c_pm: cover property (O_PM_WR);
endmodule // sgd_top_checker

bind sgd_top sgd_top_checker u_chk (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_LD_STB(O_LD_STB),
	.O_LD_CH(O_LD_CH), .O_LD_CNT(O_LD_CNT), .O_HDR_RD(O_HDR_RD), .I_HDR_VLD(I_HDR_VLD),
	.I_HDR_SIZE(I_HDR_SIZE), .O_PM_WR(O_PM_WR), .O_PM_OFS(O_PM_OFS), .O_IRQ(O_IRQ));

/* File: tb/sgd_lc_model.sv */
// sgd_lc_model: legacy controller and packet memory facing sgd_top
// assumes the bench sets header size, speed and channels that never finish
`timescale 1ns/100ps
module sgd_lc_model
	import sgd_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ld_stb,
	input  wire sgd_ch_t    i_ld_ch,
	input  wire logic       i_hdr_rd,
	input  wire sgd_word_t  i_size,
	input  wire logic       i_slow,
	input  wire logic [3:0] i_hold,
	output logic [3:0]      o_tc,
	output logic            o_hdr_vld,
	output sgd_word_t       o_hdr_size
);
	int      hcnt;
	int      tcnt;
	sgd_ch_t tch;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hcnt <= 0;
			tcnt <= 0;
			tch <= 2'h0;
			o_tc <= 4'h0;
			o_hdr_vld <= 1'b0;
			o_hdr_size <= 16'h0000;
		end else begin
			o_tc <= 4'h0;
			o_hdr_vld <= 1'b0;
			// released bus toggles so a stale size is never mistaken for an answer
			o_hdr_size <= ~o_hdr_size;
			hcnt <= i_hdr_rd ? (i_slow ? 9 : 2) : (hcnt > 0 ? hcnt - 1 : 0);
			if (hcnt == 1) begin
				o_hdr_vld <= 1'b1;
				o_hdr_size <= i_size;
			end
			tcnt <= i_ld_stb ? (i_slow ? 12 : 3) : (tcnt > 0 ? tcnt - 1 : 0);
			if (i_ld_stb)
				tch <= i_ld_ch;
			if (tcnt == 1 && !i_hold[tch])
				o_tc[tch] <= 1'b1;
		end
	end
endmodule // sgd_lc_model

/* File: tb/sgd_top_test.sv */
// sgd_top_test: register-driven tests of sgd_top with a controller model
// assumes sgd_top, sgd_lc_model and the bound checker are compiled first
`timescale 1ns/100ps
`include "sgd_cfg.svh"
module sgd_top_test
	import sgd_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	sgd_byte_t addr = 8'h00;
	sgd_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	sgd_word_t m_size = 16'h0000;
	logic m_slow = 1'b1;
	logic [3:0] m_hold = 4'h0;
	sgd_byte_t rdata, hdr_pkt, pm_pkt, pm_ofs;
	sgd_word_t ld_cnt, ld_adr, ld_adr1, hdr_size, pm_data;
	sgd_ch_t ld_ch;
	logic ld_stb, ld_m2m, hdr_rd, hdr_vld, pm_wr, irq;
	logic [3:0] tc;
	int n_mismatch = 0;
	int checked = 0;
	int n_ld = 0;
	int cyc = 0;
	always #50 mclk = ~mclk;
	sgd_top u_dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .O_LD_STB(ld_stb), .O_LD_CH(ld_ch), .O_LD_CNT(ld_cnt),
		.O_LD_ADR(ld_adr), .O_LD_M2M(ld_m2m), .O_LD_ADR1(ld_adr1), .I_TC(tc),
		.O_HDR_RD(hdr_rd), .O_HDR_PKT(hdr_pkt), .I_HDR_VLD(hdr_vld), .I_HDR_SIZE(hdr_size),
		.O_PM_WR(pm_wr), .O_PM_PKT(pm_pkt), .O_PM_OFS(pm_ofs), .O_PM_DATA(pm_data), .O_IRQ(irq));
	sgd_lc_model u_lc (.i_clk(mclk), .i_rst_n(rst_n), .i_ld_stb(ld_stb), .i_ld_ch(ld_ch),
		.i_hdr_rd(hdr_rd), .i_size(m_size), .i_slow(m_slow), .i_hold(m_hold), .o_tc(tc),
		.o_hdr_vld(hdr_vld), .o_hdr_size(hdr_size));
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (ld_stb === 1'b1)
			n_ld++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	function automatic sgd_byte_t ra(input sgd_ch_t c, input logic [2:0] r);
		return {3'h0, c, r};
	endfunction
	task automatic chk(input sgd_word_t got, input sgd_word_t exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrr(input sgd_byte_t a, input sgd_byte_t d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rdd(input sgd_byte_t a, output sgd_byte_t d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask
	task automatic rdc(input sgd_byte_t a, input sgd_byte_t exp);
		sgd_byte_t d;
		rdd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	task automatic poll(input sgd_byte_t a, input int b, input logic v);
		sgd_byte_t s;
		s = {8{~v}};
		for (int i = 0; i < 30 && s[b] !== v; i++)
			rdd(a, s);
	endtask
	task automatic cfg(input sgd_ch_t c, input sgd_byte_t cmd, input sgd_word_t sz,
		input sgd_word_t ad);
		wrr(ra(c, `SGD_REG_SIZE_HI), sz[15:8]);
		wrr(ra(c, `SGD_REG_SIZE_LO), sz[7:0]);
		wrr(ra(c, `SGD_REG_ADR_HI), ad[15:8]);
		wrr(ra(c, `SGD_REG_ADR_LO), ad[7:0]);
		wrr(ra(c, `SGD_REG_CMD), cmd);
	endtask
	task automatic wld(input sgd_ch_t c, input sgd_word_t cnt, input sgd_word_t ad);
		for (int i = 0; i < 40 && ld_stb !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({15'h0000, ld_stb}, 16'h0001);
		chk({14'h0000, ld_ch}, {14'h0000, c});
		chk(ld_cnt, cnt);
		chk(ld_adr, ad);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			rdc(ra(c[1:0], `SGD_REG_CMD), `SGD_RST_CMD);
			rdc(ra(c[1:0], `SGD_REG_STS), 8'h04);
			wrr(ra(c[1:0], `SGD_REG_CMD), 8'hf8 | {5'h00, c[1:0], 1'b0});
		end
		for (int c = 0; c < 4; c++) begin
			rdc(ra(c[1:0], `SGD_REG_CMD), {5'h00, c[1:0], 1'b0});
			wrr(ra(c[1:0], `SGD_REG_CMD), 8'h00);
		end
		rdc(8'h40, 8'h00);
		$display("registers done");
		cfg(2'd1, 8'h01, 16'h0123, 16'h4567);
		wrr(ra(2'd1, `SGD_REG_PKT), 8'h05);
		wld(2'd1, 16'h0122, 16'h4567);
		rdc(ra(2'd1, `SGD_REG_STS), 8'h84);
		poll(ra(2'd1, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd1, `SGD_REG_STS), 8'h04);
		m_slow <= 1'b0;
		m_hold <= 4'h2;
		wrr(ra(2'd1, `SGD_REG_PKT), 8'h06);
		wld(2'd1, 16'h0122, 16'h4567);
		wrr(ra(2'd1, `SGD_REG_CMD), 8'h00);
		poll(ra(2'd1, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd1, `SGD_REG_STS), 8'h04);
		$display("isa done");
		wrr(`SGD_REG_IRQ_STS, 8'hff);
		cfg(2'd2, 8'h03, 16'h0010, 16'h9999);
		wrr(ra(2'd2, `SGD_REG_PKT), 8'h3c);
		wld(2'd2, 16'h000f, 16'h3c00);
		poll(ra(2'd2, `SGD_REG_STS), 7, 1'b0);
		chk({15'h0000, irq}, 16'h0000);
		rdc(`SGD_REG_IRQ_STS, 8'h04);
		wrr(`SGD_REG_IRQ_MSK, 8'h04);
		repeat (2) @(posedge mclk);
		chk({15'h0000, irq}, 16'h0001);
		wrr(`SGD_REG_IRQ_MSK, 8'h00);
		repeat (2) @(posedge mclk);
		chk({15'h0000, irq}, 16'h0000);
		wrr(`SGD_REG_IRQ_MSK, 8'h04);
		wrr(`SGD_REG_IRQ_STS, 8'h04);
		repeat (2) @(posedge mclk);
		chk({15'h0000, irq}, 16'h0000);
		rdc(ra(2'd2, `SGD_REG_QUEUE), 8'h3c);
		m_hold <= 4'h4;
		wrr(ra(2'd2, `SGD_REG_PKT), 8'h44);
		wld(2'd2, 16'h000f, 16'h4400);
		wrr(ra(2'd2, `SGD_REG_CMD), 8'h02);
		poll(ra(2'd2, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd2, `SGD_REG_QUEUE), 8'h44);
		$display("packet memory done");
		m_hold <= 4'h0;
		m_slow <= 1'b1;
		m_size <= 16'h0050;
		cfg(2'd3, 8'h07, 16'h0000, 16'h0000);
		wrr(ra(2'd3, `SGD_REG_PKT), 8'h21);
		wld(2'd3, 16'h0047, 16'h2100);
		chk({8'h00, hdr_pkt}, 16'h0021);
		poll(ra(2'd3, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd3, `SGD_REG_QUEUE), 8'h21);
		m_size <= 16'h0008;
		cfg(2'd0, 8'h07, 16'h0000, 16'h0000);
		chk(16'(n_ld), 16'h0005);
		wrr(ra(2'd0, `SGD_REG_PKT), 8'h11);
		poll(ra(2'd0, `SGD_REG_STS), 2, 1'b0);
		chk(16'(n_ld), 16'h0005);
		rdc(ra(2'd0, `SGD_REG_QUEUE), 8'h11);
		wrr(ra(2'd0, `SGD_REG_CMD), 8'h00);
		$display("header done");
		wrr(`SGD_REG_MODE, 8'h80);
		cfg(2'd3, 8'h03, 16'h0020, 16'h0000);
		wrr(ra(2'd3, `SGD_REG_PKT), 8'h09);
		wld(2'd3, 16'h001f, 16'h0900);
		chk({15'h0000, pm_wr}, 16'h0001);
		chk({8'h00, pm_ofs}, {8'h00, `SGD_SIZE_OFS});
		poll(ra(2'd3, `SGD_REG_STS), 7, 1'b0);
		chk({8'h00, pm_pkt}, 16'h0009);
		chk(pm_data, 16'h0028);
		$display("packet write done");
		wrr(`SGD_REG_MODE, 8'h21);
		cfg(2'd0, 8'h01, 16'h0100, 16'h1000);
		cfg(2'd1, 8'h03, 16'h0040, 16'h0000);
		wrr(ra(2'd1, `SGD_REG_PKT), 8'h30);
		wrr(ra(2'd0, `SGD_REG_PKT), 8'h00);
		wld(2'd0, 16'h003f, 16'h1000);
		chk({15'h0000, ld_m2m}, 16'h0001);
		chk(ld_adr1, 16'h3000);
		poll(ra(2'd0, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd0, `SGD_REG_ADR_LO), 8'h40);
		rdc(ra(2'd0, `SGD_REG_SIZE_LO), 8'hc0);
		m_hold <= 4'h1;
		wrr(ra(2'd1, `SGD_REG_PKT), 8'h31);
		wrr(ra(2'd0, `SGD_REG_PKT), 8'h00);
		wld(2'd0, 16'h003f, 16'h1040);
		wrr(ra(2'd0, `SGD_REG_CMD), 8'h00);
		poll(ra(2'd0, `SGD_REG_STS), 7, 1'b0);
		rdc(ra(2'd0, `SGD_REG_ADR_LO), 8'h40);
		rdc(ra(2'd0, `SGD_REG_SIZE_LO), 8'hc0);
		rdc(ra(2'd1, `SGD_REG_QUEUE), 8'h30);
		rdc(ra(2'd1, `SGD_REG_QUEUE), 8'h31);
		$display("paired done");
		report_and_stop();
	end
endmodule // sgd_top_test
